// ### inc/ocd_pkg.sv
// Shared constants and types for the on-screen character display
package ocd_pkg;

  // Register map, byte addresses in the external memory space
  localparam logic [15:0] REG_BASE   = 16'hFC00;
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_VPOS   = 8'h01;
  localparam logic [7:0]  OFF_HPOS   = 8'h02;
  localparam logic [7:0]  OFF_ATTR   = 8'h03;
  localparam logic [7:0]  OFF_ROWSP  = 8'h04;
  localparam logic [7:0]  OFF_FADE   = 8'h05;
  localparam logic [7:0]  OFF_BARCTL = 8'h06;
  localparam logic [7:0]  OFF_BARPOS = 8'h07;
  localparam logic [7:0]  OFF_STATUS = 8'h08;
  localparam logic [7:0]  VRAM_PAGE  = 8'hFD;

  // Control register fields
  localparam int CTRL_CHR_EN  = 0;
  localparam int CTRL_BG_EN   = 1;
  localparam int CTRL_HS_POL  = 2;
  localparam int CTRL_VS_POL  = 3;
  localparam int CTRL_RGB_POL = 4;
  localparam int CTRL_FRG_EN  = 5;
  localparam int CTRL_PXH_LO  = 6;
  localparam int CTRL_PXH_HI  = 7;

  // Frame attribute, bar control and row attribute fields
  localparam int ATTR_FRG_LO  = 0;
  localparam int ATTR_FRG_HI  = 2;
  localparam int ATTR_BG_LO   = 3;
  localparam int ATTR_BG_HI   = 5;
  localparam int BAR_ROW_LO   = 0;
  localparam int BAR_ROW_HI   = 2;
  localparam int BAR_EN       = 3;
  localparam int BAR_COL_LO   = 4;
  localparam int BAR_COL_HI   = 6;
  localparam int RATTR_CH_LO  = 0;
  localparam int RATTR_CH_HI  = 2;
  localparam int RATTR_BG_LO  = 3;
  localparam int RATTR_BG_HI  = 5;
  localparam int RATTR_BG_EN  = 6;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [5:0] POS_RST   = 6'h00;
  localparam logic [5:0] ATTR_RST  = 6'h00;
  localparam logic [3:0] ROWSP_RST = 4'h0;
  localparam logic [6:0] BAR_RST   = 7'h00;

  // Geometry
  localparam int          TEXT_ROWS  = 6;
  localparam int          TEXT_COLS  = 20;
  localparam int          VRAM_ROWS  = 8;
  localparam int          VRAM_COLS  = 21;
  localparam int          GLYPHS     = 96;
  localparam int          ROM_WORDS  = 3072;
  localparam logic [3:0]  GLYPH_LAST = 4'd14;
  localparam logic [3:0]  GLYPH_W    = 4'd11;
  localparam logic [3:0]  CELL_LAST  = 4'd11;
  localparam logic [3:0]  HALF_CELL  = 4'd6;
  localparam logic [3:0]  FETCH_W0   = 4'd8;
  localparam logic [3:0]  FETCH_W1   = 4'd9;
  localparam logic [3:0]  LATCH_W0   = 4'd10;
  localparam logic [6:0]  CODE_FIRST = 7'h20;
  localparam logic [11:0] WORDS_PER_GLYPH = 12'd30;
  localparam logic [4:0]  COL_IDLE   = 5'h1F;
  localparam logic [4:0]  COL_LAST   = 5'd20;
  localparam logic [9:0]  LINE_PRE   = 10'h3FF;

  // Dot oscillator gating around horizontal sync
  localparam int         CLK_PERIOD_NS   = 4;
  localparam int         DOT_PERIOD_NS   = 4;
  localparam int         HALT_TPV        = 2;
  localparam int         RESTART_TPV     = 1;
  localparam logic [1:0] HALT_CYC    = 2'((HALT_TPV * DOT_PERIOD_NS) / CLK_PERIOD_NS);
  localparam logic [1:0] RESTART_CYC =
    2'((RESTART_TPV * DOT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    VS_WAIT = 2'b00,
    VS_ROW  = 2'b01,
    VS_GAP  = 2'b10,
    VS_DONE = 2'b11
  } ocd_vstate_e;

endpackage

// ### design/ocd_top.sv
// On-screen character display: registers, video memory, timing and pixel path
// Functional notes
// - Six rows, twenty columns, 96 glyphs, 11x15
// - Seven foreground colours chosen per row
// - Glyph dots stretched over 1-4 lines
// - Programmable sync input and RGB polarity
// - 64 vertical, 64 horizontal start positions
// - Row gap from 2 to 17 lines
// - Vertical fade position limits shown lines
// - One row draws half-column bar colour
// - Fringe switchable with selectable colour
// - Eight background colours including black
// - Character and background display enables
// - Glyph ROM 3K six-bit words
// - Eight row arrays, 21 seven-bit cells
// - Row attribute gives colours, background enable
// - Twenty codes per row select glyphs
// - Control registers decoded from FC00h
// - Dot oscillator restarts after hsync end
// - Interrupt on filtered vsync leading edge
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps

module ocd_top (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        hsync_i,
  input  wire logic        vsync_i,
  output logic      [11:0] rom_addr_o,
  input  wire logic [5:0]  rom_data_i,
  output logic             dot_clock_oscillator_en_o,
  output logic             vertical_sync_irq_o,
  output logic             red_overlay_out_o,
  output logic             green_overlay_out_o,
  output logic             blue_overlay_out_o,
  output logic             overlay_blank_out_o
);

  typedef struct packed {
    logic [2:0]          hs_sync;
    logic [2:0]          vs_sync;
    logic                hs_f;
    logic                vs_f;
    logic                hs_d;
    logic                vs_d;
    logic [7:0]          ctrl;
    logic [5:0]          vpos;
    logic [5:0]          hpos;
    logic [5:0]          attr;
    logic [3:0]          rowsp;
    logic [5:0]          fade;
    logic [6:0]          barctl;
    logic [5:0]          barpos;
    logic [7:0]          rdata;
    ocd_pkg::ocd_vstate_e vst;
    logic [9:0]          vl;
    logic [2:0]          row;
    logic [3:0]          gl;
    logic [1:0]          sub;
    logic [4:0]          gap;
    logic                osc_run;
    logic                osc_stop;
    logic [1:0]          osc_cnt;
    logic                hwait;
    logic [8:0]          hcnt;
    logic [4:0]          colp;
    logic [3:0]          d;
    logic [11:0]         pat;
    logic [5:0]          nxt;
    logic                prevdot;
    logic [2:0]          rgb;
    logic                blank;
    logic                irq;
    logic [11:0]         rom_addr;
  } ocd_state_s;

  ocd_state_s st;
  ocd_state_s next_st;

  // Cell 0 of each array is the attribute, 1..20 the codes
  // No reset: software fills it before enabling characters
  logic [6:0] vram [ocd_pkg::VRAM_ROWS][ocd_pkg::VRAM_COLS];

  logic       vram_hit;
  logic       reg_hit;
  logic [2:0] vram_row;
  logic [4:0] vram_col;

  // Video memory sits on its own page of the external space
  assign vram_hit = (reg_addr_i[15:8] == ocd_pkg::VRAM_PAGE) &&
                    (reg_addr_i[4:0] < 5'(ocd_pkg::VRAM_COLS));
  assign reg_hit  = (reg_addr_i[15:8] == ocd_pkg::REG_BASE[15:8]);
  assign vram_row = reg_addr_i[7:5];
  assign vram_col = reg_addr_i[4:0];

  always_ff @(posedge clk_i) begin
    if (reg_wr_i && vram_hit) begin
      vram[vram_row][vram_col] <= reg_wdata_i[6:0];
    end
  end

  // Combinational helpers
  logic        hs_act;
  logic        vs_act;
  logic        hs_lead;
  logic        hs_trail;
  logic        vs_lead;
  logic [1:0]  pxh;
  logic [7:0]  vstart;
  logic [8:0]  hstart;
  logic [6:0]  rattr;
  logic [6:0]  code;
  logic [6:0]  glyph;
  logic [11:0] glyph_base;
  logic [9:0]  rel;
  logic        vis;
  logic        in_cols;
  logic        area;
  logic        dot;
  logic        right;
  logic        char_px;
  logic        frg_px;
  logic        rbg_px;
  logic        fbg_px;
  logic        bar_hit;
  logic [5:0]  halfcol;
  logic [2:0]  colour;

  always_comb begin
    next_st = st;

    // Three-stage sync filter: accept a level once stages two and three agree
    // Reset leaves all stages low, matching an idle active-high pin
    next_st.hs_sync = {st.hs_sync[1:0], hsync_i};
    next_st.vs_sync = {st.vs_sync[1:0], vsync_i};
    if (st.hs_sync[1] == st.hs_sync[2]) begin
      next_st.hs_f = st.hs_sync[2];
    end
    if (st.vs_sync[1] == st.vs_sync[2]) begin
      next_st.vs_f = st.vs_sync[2];
    end

    // Polarity bit set means the sync input is active low
    // Flipping it while the pin idles reads as a sync edge
    hs_act   = st.hs_f ^ st.ctrl[ocd_pkg::CTRL_HS_POL];
    vs_act   = st.vs_f ^ st.ctrl[ocd_pkg::CTRL_VS_POL];
    next_st.hs_d = hs_act;
    next_st.vs_d = vs_act;
    hs_lead  = hs_act & ~st.hs_d;
    hs_trail = ~hs_act & st.hs_d;
    vs_lead  = vs_act & ~st.vs_d;
    next_st.irq = vs_lead;

    pxh    = st.ctrl[ocd_pkg::CTRL_PXH_HI:ocd_pkg::CTRL_PXH_LO];
    vstart = {st.vpos, 2'b00};
    hstart = {1'b0, st.hpos, 2'b00};
    rattr  = vram[st.row][0];

    // Register bus; read data stands one cycle only
    // Unmapped offsets read zero and ignore writes
    next_st.rdata = 8'h00;
    if (reg_wr_i && reg_hit) begin
      case (reg_addr_i[7:0])
        ocd_pkg::OFF_CTRL:   next_st.ctrl   = reg_wdata_i;
        ocd_pkg::OFF_VPOS:   next_st.vpos   = reg_wdata_i[5:0];
        ocd_pkg::OFF_HPOS:   next_st.hpos   = reg_wdata_i[5:0];
        ocd_pkg::OFF_ATTR:   next_st.attr   = reg_wdata_i[5:0];
        ocd_pkg::OFF_ROWSP:  next_st.rowsp  = reg_wdata_i[3:0];
        ocd_pkg::OFF_FADE:   next_st.fade   = reg_wdata_i[5:0];
        ocd_pkg::OFF_BARCTL: next_st.barctl = reg_wdata_i[6:0];
        ocd_pkg::OFF_BARPOS: next_st.barpos = reg_wdata_i[5:0];
        default:             next_st.ctrl   = st.ctrl;
      endcase
    end
    if (reg_rd_i && vram_hit) begin
      next_st.rdata = {1'b0, vram[vram_row][vram_col]};
    end else if (reg_rd_i && reg_hit) begin
      case (reg_addr_i[7:0])
        ocd_pkg::OFF_CTRL:   next_st.rdata = st.ctrl;
        ocd_pkg::OFF_VPOS:   next_st.rdata = {2'b00, st.vpos};
        ocd_pkg::OFF_HPOS:   next_st.rdata = {2'b00, st.hpos};
        ocd_pkg::OFF_ATTR:   next_st.rdata = {2'b00, st.attr};
        ocd_pkg::OFF_ROWSP:  next_st.rdata = {4'h0, st.rowsp};
        ocd_pkg::OFF_FADE:   next_st.rdata = {2'b00, st.fade};
        ocd_pkg::OFF_BARCTL: next_st.rdata = {1'b0, st.barctl};
        ocd_pkg::OFF_BARPOS: next_st.rdata = {2'b00, st.barpos};
        ocd_pkg::OFF_STATUS: next_st.rdata = {vs_act, hs_act, st.vst, st.osc_run, st.row};
        default:             next_st.rdata = 8'h00;
      endcase
    end

    // Dot oscillator: halt shortly after hsync starts, restart after it ends
    // A new edge reloads the count, so a short pulse cannot strand it
    if (hs_lead) begin
      next_st.osc_cnt  = ocd_pkg::HALT_CYC;
      next_st.osc_stop = 1'b1;
    end else if (hs_trail) begin
      next_st.osc_cnt  = ocd_pkg::RESTART_CYC;
      next_st.osc_stop = 1'b0;
    end else if (st.osc_cnt != 2'd0) begin
      next_st.osc_cnt = st.osc_cnt - 2'd1;
      if (st.osc_cnt == 2'd1) begin
        next_st.osc_run = ~st.osc_stop;
        next_st.hwait   = ~st.osc_stop;
        next_st.hcnt    = 9'd0;
      end
    end

    // Vertical sequencing, one step per line
    // Vsync wins over a coincident hsync, so that line is not counted
    if (vs_lead) begin
      next_st.vst = ocd_pkg::VS_WAIT;
      next_st.vl  = ocd_pkg::LINE_PRE;
      next_st.row = 3'd0;
    end else if (hs_lead) begin
      next_st.vl   = st.vl + 10'd1;
      next_st.colp = ocd_pkg::COL_IDLE;
      case (st.vst)
        ocd_pkg::VS_WAIT: begin
          if (next_st.vl == {2'b00, vstart}) begin
            next_st.vst = ocd_pkg::VS_ROW;
            next_st.row = 3'd0;
            next_st.gl  = 4'd0;
            next_st.sub = 2'd0;
          end
        end
        ocd_pkg::VS_ROW: begin
          if (st.sub == pxh) begin
            next_st.sub = 2'd0;
            if (st.gl == ocd_pkg::GLYPH_LAST) begin
              next_st.vst = ocd_pkg::VS_GAP;
              next_st.gap = 5'd0;
            end else begin
              next_st.gl = st.gl + 4'd1;
            end
          end else begin
            next_st.sub = st.sub + 2'd1;
          end
        end
        ocd_pkg::VS_GAP: begin
          // Gap lasts rowsp plus two lines
          if (st.gap == {1'b0, st.rowsp} + 5'd1) begin
            if (st.row == 3'(ocd_pkg::TEXT_ROWS - 1)) begin
              next_st.vst = ocd_pkg::VS_DONE;
            end else begin
              next_st.vst = ocd_pkg::VS_ROW;
              next_st.row = st.row + 3'd1;
              next_st.gl  = 4'd0;
              next_st.sub = 2'd0;
            end
          end else begin
            next_st.gap = st.gap + 5'd1;
          end
        end
        default: next_st.vst = st.vst;
      endcase
    end

    // Horizontal: wait hstart dots, one lead-in cell, then 20 cells
    // The lead-in cell only prefetches column one; it is never drawn
    if (st.osc_run && !hs_lead) begin
      if (st.hwait) begin
        if (st.hcnt == hstart) begin
          next_st.hwait = 1'b0;
          next_st.colp  = 5'd0;
          next_st.d     = 4'd0;
        end else begin
          next_st.hcnt = st.hcnt + 9'd1;
        end
      end else if (st.colp != ocd_pkg::COL_IDLE) begin
        if (st.d == ocd_pkg::CELL_LAST) begin
          next_st.d    = 4'd0;
          next_st.colp = (st.colp == ocd_pkg::COL_LAST) ? ocd_pkg::COL_IDLE : st.colp + 5'd1;
        end else begin
          next_st.d = st.d + 4'd1;
        end
      end
    end

    // Glyph fetch for the next cell, two six-bit words per glyph line
    // ROM answers a cycle after its address, hence fetch at d8, d9 and latch at d10, d11
    code       = (st.colp < ocd_pkg::COL_LAST) ? vram[st.row][st.colp + 5'd1] : ocd_pkg::CODE_FIRST;
    glyph      = (code < ocd_pkg::CODE_FIRST) ? 7'd0 : code - ocd_pkg::CODE_FIRST;
    glyph_base = 12'(glyph) * ocd_pkg::WORDS_PER_GLYPH + {7'd0, st.gl, 1'b0};
    if (st.d == ocd_pkg::FETCH_W0) begin
      next_st.rom_addr = glyph_base;
    end else if (st.d == ocd_pkg::FETCH_W1) begin
      next_st.rom_addr = glyph_base + 12'd1;
    end
    if (st.osc_run && st.colp != ocd_pkg::COL_IDLE) begin
      if (st.d == ocd_pkg::LATCH_W0) begin
        next_st.nxt = rom_data_i;
      end else if (st.d == ocd_pkg::CELL_LAST) begin
        next_st.pat = {st.nxt, rom_data_i};
      end
    end

    // Pixel selection
    // Fringe looks one dot left and right on the same line; no vertical outline
    rel     = st.vl - {2'b00, vstart};
    vis     = (st.fade == 6'd0) || (rel < {2'b00, st.fade, 2'b00});
    in_cols = (st.colp != 5'd0) && (st.colp <= ocd_pkg::COL_LAST);
    area    = st.osc_run && in_cols && vis &&
              (st.vst == ocd_pkg::VS_ROW || st.vst == ocd_pkg::VS_GAP);
    dot     = (st.d < ocd_pkg::GLYPH_W) && st.pat[4'd11 - st.d];
    right   = (st.d < ocd_pkg::GLYPH_W - 4'd1) && st.pat[4'd10 - st.d];
    next_st.prevdot = area && dot;
    char_px = st.ctrl[ocd_pkg::CTRL_CHR_EN] && area && (st.vst == ocd_pkg::VS_ROW) && dot;
    frg_px  = st.ctrl[ocd_pkg::CTRL_CHR_EN] && st.ctrl[ocd_pkg::CTRL_FRG_EN] && area &&
              (st.vst == ocd_pkg::VS_ROW) && !dot && (st.prevdot || right);
    rbg_px  = st.ctrl[ocd_pkg::CTRL_BG_EN] && area && (st.vst == ocd_pkg::VS_ROW) &&
              rattr[ocd_pkg::RATTR_BG_EN];
    fbg_px  = st.ctrl[ocd_pkg::CTRL_BG_EN] && area;
    halfcol = {st.colp - 5'd1, 1'b0} + {5'd0, st.d >= ocd_pkg::HALF_CELL};
    bar_hit = st.barctl[ocd_pkg::BAR_EN] &&
              (st.row == st.barctl[ocd_pkg::BAR_ROW_HI:ocd_pkg::BAR_ROW_LO]) &&
              (halfcol < st.barpos);

    if (char_px) begin
      colour = bar_hit ? st.barctl[ocd_pkg::BAR_COL_HI:ocd_pkg::BAR_COL_LO]
                       : rattr[ocd_pkg::RATTR_CH_HI:ocd_pkg::RATTR_CH_LO];
    end else if (frg_px) begin
      colour = st.attr[ocd_pkg::ATTR_FRG_HI:ocd_pkg::ATTR_FRG_LO];
    end else if (rbg_px) begin
      colour = rattr[ocd_pkg::RATTR_BG_HI:ocd_pkg::RATTR_BG_LO];
    end else if (fbg_px) begin
      colour = st.attr[ocd_pkg::ATTR_BG_HI:ocd_pkg::ATTR_BG_LO];
    end else begin
      colour = 3'd0;
    end
    // Inverted polarity also inverts the idle level
    next_st.rgb   = colour ^ {3{st.ctrl[ocd_pkg::CTRL_RGB_POL]}};
    next_st.blank = char_px | frg_px | rbg_px | fbg_px;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st          <= '0;
      st.ctrl     <= ocd_pkg::CTRL_RST;
      st.vpos     <= ocd_pkg::POS_RST;
      st.hpos     <= ocd_pkg::POS_RST;
      st.attr     <= ocd_pkg::ATTR_RST;
      st.rowsp    <= ocd_pkg::ROWSP_RST;
      st.barctl   <= ocd_pkg::BAR_RST;
      st.barpos   <= ocd_pkg::POS_RST;
      st.vst      <= ocd_pkg::VS_DONE;
      st.vl       <= ocd_pkg::LINE_PRE;
      // Oscillator runs from reset so the first hsync halts it cleanly
      st.osc_run  <= 1'b1;
      st.colp     <= ocd_pkg::COL_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o               = st.rdata;
  assign rom_addr_o                = st.rom_addr;
  assign dot_clock_oscillator_en_o = st.osc_run;
  assign vertical_sync_irq_o       = st.irq;
  assign red_overlay_out_o         = st.rgb[2];
  assign green_overlay_out_o       = st.rgb[1];
  assign blue_overlay_out_o        = st.rgb[0];
  assign overlay_blank_out_o       = st.blank;

endmodule

// ### tb/ocd_assertions.sv
// Port-level concurrent checks for the character display
`timescale 1ns/1ps
module ocd_checker (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        hsync_i,
  input wire logic        vsync_i,
  input wire logic [11:0] rom_addr_o,
  input wire logic [5:0]  rom_data_i,
  input wire logic        dot_clock_oscillator_en_o,
  input wire logic        vertical_sync_irq_o,
  input wire logic        red_overlay_out_o,
  input wire logic        green_overlay_out_o,
  input wire logic        blue_overlay_out_o,
  input wire logic        overlay_blank_out_o
);
  logic [3:0] hs_age;
  logic [3:0] vs_age;
  logic       hs_q;
  logic       vs_q;

  // Cycles since each sync pin last moved, saturating so long lines stay legal
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hs_q   <= 1'b0;
      vs_q   <= 1'b0;
      hs_age <= 4'hF;
      vs_age <= 4'hF;
    end else begin
      hs_q   <= hsync_i;
      vs_q   <= vsync_i;
      hs_age <= (hsync_i != hs_q) ? 4'h0 : ((hs_age == 4'hF) ? hs_age : hs_age + 4'h1);
      vs_age <= (vsync_i != vs_q) ? 4'h0 : ((vs_age == 4'hF) ? vs_age : vs_age + 4'h1);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence rd_unmapped;
    $past(reg_rd_i) && $past(reg_addr_i[15:8]) != ocd_pkg::REG_BASE[15:8]
      && $past(reg_addr_i[15:8]) != ocd_pkg::VRAM_PAGE;
  endsequence
  sequence rd_vram;
    $past(reg_rd_i) && $past(reg_addr_i[15:8]) == ocd_pkg::VRAM_PAGE;
  endsequence
  sequence osc_stopped;
    !dot_clock_oscillator_en_o [*3];
  endsequence

  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read cycle");
  unmapped_read_a: assert property (rd_unmapped |-> reg_rdata_o == 8'h00)
    else $error("unmapped read returned data");
  vram_msb_a: assert property (rd_vram |-> !reg_rdata_o[7])
    else $error("video memory read has bit 7 set");
  irq_single_a: assert property (vertical_sync_irq_o |=> !vertical_sync_irq_o)
    else $error("sync interrupt longer than one cycle");
  irq_cause_a: assert property (vertical_sync_irq_o |-> vs_age >= 4'd2 && vs_age <= 4'd10)
    else $error("sync interrupt without recent vertical sync edge");
  osc_restart_a: assert property ($rose(dot_clock_oscillator_en_o) |-> hs_age >= 4'd2 && hs_age <= 4'd11)
    else $error("dot oscillator restart too early or unrelated to sync");
  osc_halt_a: assert property ($fell(dot_clock_oscillator_en_o) |-> hs_age >= 4'd2 && hs_age <= 4'd11)
    else $error("dot oscillator halt unrelated to sync");
  blank_gated_a: assert property (osc_stopped |-> !overlay_blank_out_o)
    else $error("overlay drawn while dot oscillator stopped");
  rom_range_a: assert property (rom_addr_o < 12'(ocd_pkg::ROM_WORDS))
    else $error("glyph address beyond table");
  reset_state_a: assert property (disable iff (1'b0) $fell(sys_rst_i) |->
      dot_clock_oscillator_en_o && !overlay_blank_out_o && !vertical_sync_irq_o)
    else $error("outputs wrong at reset release");
  irq_seen_c: cover property (vertical_sync_irq_o);
endmodule

bind ocd_top ocd_checker chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .hsync_i(hsync_i), .vsync_i(vsync_i), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
  .dot_clock_oscillator_en_o(dot_clock_oscillator_en_o), .vertical_sync_irq_o(vertical_sync_irq_o),
  .red_overlay_out_o(red_overlay_out_o), .green_overlay_out_o(green_overlay_out_o),
  .blue_overlay_out_o(blue_overlay_out_o), .overlay_blank_out_o(overlay_blank_out_o));

// ### tb/ocd_video_model.sv
// Sync source, glyph ROM and overlay monitor on the video side
`timescale 1ns/1ps
module ocd_video_model #(
  parameter int GLYPH = 33
) (
  input  wire logic        clk_i,
  input  wire logic        sync_low_i,
  input  wire logic [2:0]  exp_rgb_i,
  input  wire logic [11:0] rom_addr_i,
  input  wire logic        red_i,
  input  wire logic        green_i,
  input  wire logic        blue_i,
  input  wire logic        blank_i,
  output logic             hsync_o,
  output logic             vsync_o,
  output logic [5:0]       rom_data_o,
  output int               blank_cnt_o,
  output int               bad_cnt_o
);
  logic hs_act;
  logic vs_act;

  initial begin
    hs_act = 1'b0;
    vs_act = 1'b0;
    rom_data_o = 6'h00;
    blank_cnt_o = 0;
    bad_cnt_o = 0;
  end
  assign hsync_o = hs_act ^ sync_low_i;
  assign vsync_o = vs_act ^ sync_low_i;

  // Only the one glyph in use is lit, all 30 words of it, so a wrong code gives no dots
  always @(posedge clk_i) begin
    rom_data_o <= (rom_addr_i >= 12'(GLYPH * 30) && rom_addr_i < 12'(GLYPH * 30 + 30)) ? 6'h3F : 6'h00;
  end

  always @(posedge clk_i) begin
    if (blank_i === 1'b1) begin
      blank_cnt_o <= blank_cnt_o + 1;
      if ({red_i, green_i, blue_i} !== exp_rgb_i) bad_cnt_o <= bad_cnt_o + 1;
    end
  end

  // Lines of 300 dots, 20 of sync; vertical sync over the first 3 lines
  task automatic frame(input int lines);
    for (int l = 0; l < lines; l++) begin
      for (int c = 0; c < 300; c++) begin
        @(posedge clk_i);
        hs_act <= (c < 20);
        if (c == 0) vs_act <= (l < 3);
      end
    end
  endtask
endmodule

// ### tb/onscreen_character_display_bench.sv
// Self-checking bench for the on-screen character display
`timescale 1ns/1ps
module onscreen_character_display_bench;
  logic        clk_i;
  logic        sys_rst_i;
  logic [15:0] reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic        hsync_i;
  logic        vsync_i;
  logic [11:0] rom_addr_o;
  logic [5:0]  rom_data_i;
  logic        osc_en;
  logic        irq;
  logic        red;
  logic        green;
  logic        blue;
  logic        blank;
  logic        sync_low;
  logic [2:0]  exp_rgb;
  logic [7:0]  rd_val;
  int          blank_cnt;
  int          bad_cnt;
  int          irq_cnt;
  int          fails;
  int          checked;
  logic [7:0]  mask [8] = '{8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h0F, 8'h3F, 8'h7F, 8'h3F};
  logic [7:0]  cfg  [8] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  ocd_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .hsync_i(hsync_i), .vsync_i(vsync_i),
    .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i), .dot_clock_oscillator_en_o(osc_en),
    .vertical_sync_irq_o(irq), .red_overlay_out_o(red), .green_overlay_out_o(green),
    .blue_overlay_out_o(blue), .overlay_blank_out_o(blank));

  ocd_video_model vid_u (.clk_i(clk_i), .sync_low_i(sync_low), .exp_rgb_i(exp_rgb), .rom_addr_i(rom_addr_o),
    .red_i(red), .green_i(green), .blue_i(blue), .blank_i(blank), .hsync_o(hsync_i), .vsync_o(vsync_i),
    .rom_data_o(rom_data_i), .blank_cnt_o(blank_cnt), .bad_cnt_o(bad_cnt));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (irq === 1'b1) irq_cnt++;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Memory-mapped load cycles: one strobe cycle each
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // Filtered pin level and polarity bit land on one edge, so no false sync edge
  task automatic pol_wr(input logic [7:0] c, input logic low);
    @(posedge clk_i);
    sync_low <= low;
    repeat (2) @(posedge clk_i);
    wr(16'hFC00, c);
  endtask

  task automatic run_frame(input logic [7:0] ctrl, input logic low, input logic [2:0] rgb,
                           input int lines, input int exp_blank);
    int b0;
    int x0;
    int i0;
    pol_wr(ctrl, low);
    exp_rgb <= rgb;
    // Pin level and polarity flip on one edge, so no false edge; idle a little before counting
    repeat (20) @(posedge clk_i);
    b0 = blank_cnt;
    x0 = bad_cnt;
    i0 = irq_cnt;
    vid_u.frame(lines);
    repeat (300) @(posedge clk_i);
    chk("blank_count", exp_blank, blank_cnt - b0);
    chk("colour_err", 0, bad_cnt - x0);
    chk("irq_count", 1, irq_cnt - i0);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #360000;
    fails++;
    stop_test;
  end

  initial begin
    sys_rst_i = 1'b1;
    reg_addr_i = 16'h0000;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    sync_low = 1'b0;
    exp_rgb = 3'h0;
    irq_cnt = 0;
    fails = 0;
    checked = 0;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("osc_reset", 1, osc_en);
    chk("blank_reset", 0, blank);
    chk("irq_reset", 0, irq);
    chk("rdata_reset", 0, reg_rdata_o);
    rd(16'hFC08, rd_val);
    chk("status_reset", 8'h38, rd_val);
    for (int i = 0; i < 8; i++) begin
      // Both sync polarities flip together with the pin levels
      if (i == 0) pol_wr(8'hFF, 1'b1);
      else wr(16'hFC00 + 16'(i), 8'hFF);
      rd(16'hFC00 + 16'(i), rd_val);
      chk("reg_width", mask[i], rd_val);
    end
    rd(16'hFC09, rd_val);
    chk("unmapped_reg", 0, rd_val);
    rd(16'hFE00, rd_val);
    chk("unmapped_page", 0, rd_val);
    wr(16'hFD01, 8'hFF);
    rd(16'hFD01, rd_val);
    chk("vram_width", 8'h7F, rd_val);
    wr(16'hFD15, 8'h55);
    rd(16'hFD15, rd_val);
    chk("vram_col21", 0, rd_val);
    // Char colour 5, row background off, every cell the same glyph
    for (int r = 0; r < 8; r++)
      for (int c = 0; c < 21; c++)
        wr(16'hFD00 + 16'(r * 32 + c), (c == 0) ? 8'h05 : 8'h41);
    rd(16'hFDF4, rd_val);
    chk("vram_last", 8'h41, rd_val);
    rd(16'hFD00, rd_val);
    chk("vram_attr", 8'h05, rd_val);
    // Control goes last, just before the first frame, with its pin levels
    for (int i = 7; i >= 1; i--) wr(16'hFC00 + 16'(i), cfg[i]);
    run_frame(cfg[0], 1'b0, 3'h5, 120, 19800);
    run_frame(8'h1D, 1'b1, 3'h2, 38, 6600);
    run_frame(8'h41, 1'b0, 3'h5, 36, 6600);
    run_frame(8'h00, 1'b0, 3'h5, 36, 0);
    // Frame background in the character colour; fade keeps 16 lines
    wr(16'hFC03, 8'h28);
    wr(16'hFC05, 8'h04);
    run_frame(8'h03, 1'b0, 3'h5, 36, 3840);
    stop_test;
  end
endmodule
